// file: rtl/flash_ctrl_security_regs.sv
// Flash front register bank: clock divider, security byte, configuration.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module flash_ctrl_security_regs
    import flash_regs_pkg::*;
(
    input wire logic sys_clk, // Bus clock, 25 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [7:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr_stb, // Write strobe.
    input wire logic rd_stb, // Read strobe.
    output logic [7:0] rdata, // Read data, valid the cycle after rd_stb.
    input wire logic osc_clk_in, // Oscillator clock sampled as a level.
    input wire logic cfg_load, // Pulse: load security byte from configuration.
    input wire logic [7:0] cfg_sec_byte, // Configuration byte value.
    input wire logic backdoor_unsecure, // Pulse: backdoor key access succeeded.
    input wire logic buffer_empty_flag, // Command buffer empty level.
    input wire logic cmd_complete_flag, // Command complete level.
    output logic flash_clk_tick, // One-cycle pulse per flash clock period.
    output logic [7:0] divider_value, // Divider register contents.
    output logic key_access_en, // Backdoor key enable state.
    output logic secured, // Device secured level.
    output logic array_key_mode, // Array writes taken as key words.
    output logic array_read_invalid, // Array reads return invalid data.
    output logic irq // Level interrupt request.
);
    logic [6:0] div_q;
    logic loaded_q;
    logic [7:0] sec_q;
    logic [2:0] cfg_q;
    logic [1:0] irq_st_q;
    logic [1:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic [2:0] pre_q;
    logic [5:0] fdiv_q;
    logic tick_q;
    logic irq_q;
    logic buf_s1_q, buf_s2_q, cmd_s1_q, cmd_s2_q;
    logic bu_s1_q, bu_s2_q;

    wire wr_div = wr_stb && (addr == OFS_CLKDIV);
    wire wr_cfg = wr_stb && (addr == OFS_CFG);
    wire wr_mask = wr_stb && (addr == OFS_IRQ_MASK);
    wire rd_status = rd_stb && (addr == OFS_IRQ_STATUS);
    wire key_en = (sec_q[7:6] == KEY_ENABLED);
    wire osc_rise = osc_s2_q && !osc_s3_q;
    wire pre_done = !div_q[BIT_PRESCALE] || (pre_q == PRESCALE_LAST);
    wire pre_tick = osc_rise && pre_done;
    wire fdiv_done = (fdiv_q == div_q[5:0]);
    wire [1:0] ev = {buf_s2_q && cfg_q[2], cmd_s2_q && cfg_q[1]};
    wire [1:0] st_d = (rd_status ? IRQ_RESET : irq_st_q) | ev;
    wire [7:0] rd_mux =
        (addr == OFS_CLKDIV) ? {loaded_q, div_q} :
        (addr == OFS_SEC) ? sec_q :
        (addr == OFS_TEST) ? 8'h00 :
        (addr == OFS_CFG) ? {cfg_q, 5'h00} :
        (addr == OFS_IRQ_STATUS) ? {6'h00, irq_st_q} :
        (addr == OFS_IRQ_MASK) ? {6'h00, irq_mask_q} : 8'h00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            buf_s1_q <= 1'b0;
            buf_s2_q <= 1'b0;
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            bu_s1_q <= 1'b0;
            bu_s2_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            buf_s1_q <= buffer_empty_flag;
            buf_s2_q <= buf_s1_q;
            cmd_s1_q <= cmd_complete_flag;
            cmd_s2_q <= cmd_s1_q;
            bu_s1_q <= backdoor_unsecure;
            bu_s2_q <= bu_s1_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= DIV_RESET;
            loaded_q <= 1'b0;
        end else if (wr_div && !loaded_q) begin
            div_q <= wdata[6:0];
            loaded_q <= 1'b1;
        end
    end

    // The security byte clears during reset and loads from the configuration byte on cfg_load.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sec_q <= SEC_RESET;
        end else if (cfg_load) begin
            sec_q <= cfg_sec_byte;
        end else if (bu_s2_q) begin
            sec_q[1:0] <= SEC_UNSECURED;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q[2] <= wdata[BIT_BUF_IE];
            cfg_q[1] <= wdata[BIT_CMD_IE];
            if (key_en) begin
                cfg_q[0] <= wdata[BIT_KEY_WRITE_ACCESS];
            end
        end
    end

    // Flash timing clock: prescaler then six-bit divider, no ticks before load.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_q <= PRE_RESET;
            fdiv_q <= FDIV_RESET;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (osc_rise) begin
                pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
            end
            if (pre_tick && loaded_q) begin
                fdiv_q <= fdiv_done ? 6'h00 : fdiv_q + 6'h01;
                tick_q <= fdiv_done;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_st_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
            irq_q <= 1'b0;
            rdata_q <= RDATA_RESET;
        end else begin
            irq_st_q <= st_d;
            if (wr_mask) begin
                irq_mask_q <= wdata[1:0];
            end
            irq_q <= |(st_d & (wr_mask ? wdata[1:0] : irq_mask_q));
            rdata_q <= rd_stb ? rd_mux : 8'h00;
        end
    end

    logic [7:0] divv_q;
    logic keyen_q, secd_q, keym_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divv_q <= 8'h00;
            keyen_q <= 1'b0;
            secd_q <= SECURED_RESET;
            keym_q <= 1'b0;
        end else begin
            divv_q <= {loaded_q, div_q};
            keyen_q <= key_en;
            secd_q <= (sec_q[1:0] != SEC_UNSECURED);
            keym_q <= cfg_q[0];
        end
    end

    assign rdata = rdata_q;
    assign flash_clk_tick = tick_q;
    assign divider_value = divv_q;
    assign key_access_en = keyen_q;
    assign secured = secd_q;
    assign array_key_mode = keym_q;
    assign array_read_invalid = keym_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// file: pkg/flash_regs_pkg.sv
// Constants for the flash front register bank.
package flash_regs_pkg;
    localparam logic [7:0] OFS_CLKDIV = 8'h00;
    localparam logic [7:0] OFS_SEC = 8'h01;
    localparam logic [7:0] OFS_TEST = 8'h02;
    localparam logic [7:0] OFS_CFG = 8'h03;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h11;
    localparam int BIT_LOADED = 7;
    localparam int BIT_PRESCALE = 6;
    localparam int BIT_BUF_IE = 7;
    localparam int BIT_CMD_IE = 6;
    localparam int BIT_KEY_WRITE_ACCESS = 5;
    localparam logic [1:0] KEY_ENABLED = 2'h2;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [6:0] DIV_RESET = 7'h00;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [2:0] PRE_RESET = 3'h0;
    localparam logic [5:0] FDIV_RESET = 6'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic SECURED_RESET = 1'b1;
endpackage

// file: tb/flash_regs_checker.sv
// Port assertions for the flash register bank.
`timescale 1ns/1ns
`default_nettype none
module flash_regs_checker
    import flash_regs_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic [7:0] addr, // Address.
    input wire logic rd_stb, // Read strobe.
    input wire logic [7:0] rdata, // Read data.
    input wire logic flash_clk_tick, // Tick.
    input wire logic [7:0] divider_value, // Divider.
    input wire logic key_access_en, // Key enable.
    input wire logic secured, // Secured.
    input wire logic array_key_mode, // Key mode.
    input wire logic array_read_invalid // Read invalid.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence sec_read;
        rd_stb && addr == OFS_SEC ##1 1'b1;
    endsequence
    a_test_reads_zero: assert property ($past(rd_stb) && $past(addr) == OFS_TEST |-> rdata == 8'h00)
        else $error("reserved register read not zero");
    a_cfg_unused_zero: assert property ($past(rd_stb) && $past(addr) == OFS_CFG |-> rdata[4:0] == 5'h00)
        else $error("unused config bits not zero");
    a_loaded_sticks: assert property (divider_value[BIT_LOADED] |=> divider_value[BIT_LOADED])
        else $error("loaded flag dropped");
    a_div_write_once: assert property (divider_value[BIT_LOADED] |=> $stable(divider_value))
        else $error("divider changed after load");
    a_tick_needs_div: assert property (flash_clk_tick |-> divider_value[BIT_LOADED])
        else $error("tick before divider load");
    a_key_mode_pair: assert property (array_key_mode == array_read_invalid)
        else $error("key mode outputs disagree");
    a_key_gated: assert property ($rose(array_key_mode) |-> key_access_en)
        else $error("key bit set while key disabled");
    a_sec_decode: assert property (sec_read |-> secured == (rdata[1:0] != SEC_UNSECURED)
        && key_access_en == (rdata[7:6] == KEY_ENABLED))
        else $error("security decode wrong");
endmodule
bind flash_ctrl_security_regs flash_regs_checker i_chk (.*);
`default_nettype wire

// file: tb/test_flash_ctrl_security_regs.sv
// Self-checking bench for the flash register bank.
`timescale 1ns/1ns
`default_nettype none
module test_flash_ctrl_security_regs import flash_regs_pkg::*;;
    logic sys_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, osc = 0, ld = 0, bdu = 0, bef = 0, ccf = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, sbyte = 8'h00, rdata, divv;
    logic tick, key_en, secured, key_mode, rd_inv, irq;
    int num_errors = 0, num_checks = 0, cyc = 0, last = 0, gap = 0;
    always #20 sys_clk = ~sys_clk;
    flash_ctrl_security_regs i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .osc_clk_in(osc), .cfg_load(ld),
        .cfg_sec_byte(sbyte), .backdoor_unsecure(bdu), .buffer_empty_flag(bef),
        .cmd_complete_flag(ccf), .flash_clk_tick(tick), .divider_value(divv),
        .key_access_en(key_en), .secured(secured), .array_key_mode(key_mode),
        .array_read_invalid(rd_inv), .irq(irq));
    task automatic tally_and_finish();
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic load(input logic [7:0] b);
        sbyte <= b;
        ld <= 1'b1;
        @(posedge sys_clk);
        ld <= 1'b0;
    endtask
    task automatic flags();
        bef <= 1'b1;
        ccf <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bef <= 1'b0;
        ccf <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask
    // The oscillator rises every fourth bus cycle; tick spacing is measured in bus cycles.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) osc <= ~osc;
        if (tick) begin
            last <= cyc;
            gap <= cyc - last;
        end
        if (cyc == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_CLKDIV, 8'h00);
        rd(OFS_CFG, 8'h00);
        wr(OFS_TEST, 8'hFF);
        rd(OFS_TEST, 8'h00);
        load(8'h8A);
        wr(OFS_SEC, 8'hFF);
        rd(OFS_SEC, 8'h8A);
        wr(OFS_CFG, 8'hFF);
        rd(OFS_CFG, 8'hE0);
        chk({6'h00, key_mode, rd_inv}, 8'h03);
        wr(OFS_CFG, 8'h00);
        load(8'h41);
        wr(OFS_CFG, 8'h20);
        rd(OFS_CFG, 8'h00);
        chk({6'h00, key_en, secured}, 8'h01);
        bdu <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bdu <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd(OFS_SEC, 8'h42);
        chk({6'h00, key_en, secured}, 8'h00);
        wr(OFS_CLKDIV, 8'h45);
        wr(OFS_CLKDIV, 8'h00);
        rd(OFS_CLKDIV, 8'hC5);
        chk(divv, 8'hC5);
        repeat (500) @(posedge sys_clk);
        chk(gap[7:0], 8'hC0);
        wr(OFS_IRQ_MASK, 8'h03);
        wr(OFS_CFG, 8'h40);
        flags();
        chk({7'h00, irq}, 8'h01);
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_CFG, 8'h80);
        flags();
        wr(OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        rd(OFS_IRQ_STATUS, 8'h02);
        rd(8'h20, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
